// [fupl_pkg.sv]
// package for the flash user program and hard lock block
// assumes one system clock and an active low asynchronous reset
`default_nettype none
package fupl_pkg;
  localparam logic [7:0] UNLOCK_KEY      = 8'ha5;
  localparam logic [7:0] UNLOCK_CLEAR    = 8'h00;
  localparam logic [7:0] CMD_PROGRAM     = 8'h51;
  localparam logic [7:0] CMD_ERASE       = 8'ha1;
  localparam logic [7:0] CMD_HARD_LOCK   = 8'h61;
  localparam logic [3:0] HARD_LOCK_NIB   = 4'h6;
  localparam int         HARD_LOCK_MSB   = 7;
  localparam int         HARD_LOCK_LSB   = 4;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam int         ADDR_W          = 16;
  localparam int         SECTOR_BYTES    = 128;
  localparam int         SECTOR_SHIFT    = 7;
  localparam int         ERASE_STATUS_BIT = 3;
  // register selectors on the core command bus
  localparam logic [1:0] SEL_UNLOCK      = 2'h0;
  localparam logic [1:0] SEL_CONTROL     = 2'h1;
  localparam logic [1:0] SEL_SECT_HIGH   = 2'h2;
  localparam logic [1:0] SEL_SECT_LOW    = 2'h3;
  localparam logic [15:0] BOOT_BASE      = 16'h0100;
endpackage
`default_nettype wire

// [fupl_if.sv]
// interface between processor core end and flash controller end
// assumes both ends run on the same clock
`default_nettype none
interface fupl_if;
  logic        reg_wr;
  logic [1:0]  reg_sel;
  logic [7:0]  reg_wdata;
  logic        tbl_load;
  logic        tbl_store;
  logic [15:0] tbl_addr;
  logic [7:0]  tbl_wdata;
  logic [7:0]  tbl_rdata;
  logic        tbl_rvalid;
  logic        tbl_done;
  logic [7:0]  status;
  modport ctrl (input reg_wr, reg_sel, reg_wdata, tbl_load, tbl_store,
                tbl_addr, tbl_wdata,
                output tbl_rdata, tbl_rvalid, tbl_done, status);
  modport core (output reg_wr, reg_sel, reg_wdata, tbl_load, tbl_store,
                tbl_addr, tbl_wdata,
                input tbl_rdata, tbl_rvalid, tbl_done, status);
endinterface
`default_nettype wire

// [fupl_core_end.sv]
// core end: runs program, read, erase and lock sequences on request
// assumes the flash controller end answers each table move in a cycle
`default_nettype none
module fupl_core_end
  import fupl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  fupl_if.core             bus,
  input  wire logic        req,
  input  wire logic [1:0]  req_op,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_data,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata
);
  // req_op: 0 program, 1 read, 2 erase sector, 3 hard lock
  typedef enum logic [7:0] {
    S_IDLE = 8'b00000001, S_UNLK = 8'b00000010, S_SECH = 8'b00000100,
    S_SECL = 8'b00001000, S_CMD  = 8'b00010000, S_TBL  = 8'b00100000,
    S_NOP  = 8'b01000000, S_RLCK = 8'b10000000
  } fupl_cst_t;
  fupl_cst_t   st_q, st_d;
  logic [1:0]  op_q;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic        rd;
  assign rd = (op_q == 2'd1);
  wire [7:0] cmd_w = (op_q == 2'd0) ? CMD_PROGRAM :
                     (op_q == 2'd2) ? CMD_ERASE : CMD_HARD_LOCK;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: if (req) st_d = (req_op == 2'd1) ? S_TBL : S_UNLK;
      S_UNLK: st_d = (op_q == 2'd3) ? S_CMD : S_SECH;
      S_SECH: st_d = S_SECL;
      S_SECL: st_d = S_CMD;
      S_CMD:  st_d = (op_q == 2'd0) ? S_TBL : S_NOP;
      S_TBL:  st_d = rd ? S_IDLE : S_NOP;
      S_NOP:  st_d = S_RLCK;
      S_RLCK: st_d = S_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE; op_q <= 2'd0; addr_q <= '0; data_q <= '0;
      busy <= 1'b0; done <= 1'b0; rdata <= '0;
      bus.reg_wr <= 1'b0; bus.reg_sel <= SEL_UNLOCK;
      bus.reg_wdata <= '0; bus.tbl_load <= 1'b0; bus.tbl_store <= 1'b0;
      bus.tbl_addr <= '0; bus.tbl_wdata <= '0;
    end else begin
      st_q <= st_d;
      bus.reg_wr <= 1'b0;
      bus.tbl_load <= 1'b0;
      bus.tbl_store <= 1'b0;
      done <= 1'b0;
      if (st_q == S_IDLE && req) begin
        op_q <= req_op; addr_q <= req_addr; data_q <= req_data;
        busy <= 1'b1;
      end
      if (bus.tbl_rvalid) rdata <= bus.tbl_rdata;
      unique case (st_d)
        S_UNLK: begin
          bus.reg_wr <= 1'b1; bus.reg_sel <= SEL_UNLOCK;
          bus.reg_wdata <= UNLOCK_KEY;
        end
        S_SECH: begin
          bus.reg_wr <= 1'b1; bus.reg_sel <= SEL_SECT_HIGH;
          bus.reg_wdata <= addr_q[15:8];
        end
        S_SECL: begin
          bus.reg_wr <= 1'b1; bus.reg_sel <= SEL_SECT_LOW;
          bus.reg_wdata <= {addr_q[7], 7'h00};
        end
        S_CMD: begin
          bus.reg_wr <= 1'b1; bus.reg_sel <= SEL_CONTROL;
          bus.reg_wdata <= cmd_w;
        end
        S_TBL: begin
          bus.tbl_addr <= (st_q == S_IDLE) ? req_addr : addr_q;
          bus.tbl_wdata <= data_q;
          bus.tbl_load <= (st_q == S_IDLE);
          bus.tbl_store <= (st_q != S_IDLE);
        end
        S_RLCK: begin
          bus.reg_wr <= 1'b1; bus.reg_sel <= SEL_UNLOCK;
          bus.reg_wdata <= UNLOCK_CLEAR;
        end
        default: ;
      endcase
      if (st_q != S_IDLE && st_d == S_IDLE) begin
        busy <= 1'b0; done <= 1'b1;
      end
    end
  end
  // S_NOP leaves an idle cycle before relock
  // callers erase a sector (op 2) before programming into it
endmodule
`default_nettype wire

// [fupl_flash_ctrl.sv]
// flash controller end: unlock, command, sector registers, array, lock
// assumes the core end drives one request per cycle, synchronous to clk
`default_nettype none
// Notes on behaviour
// - program one byte, only into erased sector
// - core loads sector registers before programming
// - callers erase target sectors before programming
// - key a5 unlocks; commands need unlock
// - control 51 arms byte program store
// - core gives address in register pair
// - core relocks with zero after commands
// - table load returns byte at address
// - upper nibble 6 enables hard lock
// - hard lock blocks program stores, sector erases
// - hard lock cleared only by tool erase
// - lock accepted from firmware or tool mode
// - core locks by unlock, 61, relock
// - sectors are 128 bytes each
// - boot sector blocks program and erase
module fupl_flash_ctrl
  import fupl_pkg::*;
#(
  parameter int MEM_BYTES = 49152
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  fupl_if.ctrl             bus,
  input  wire logic        boot_sector_en,
  input  wire logic [15:0] boot_sector_top,
  input  wire logic        tool_mode,
  input  wire logic        tool_lock,
  input  wire logic        tool_chip_erase,
  output logic             hard_lock,
  output logic             unlocked,
  output logic             error
);
  localparam int SECTORS = MEM_BYTES / SECTOR_BYTES;
  localparam int IDX_W   = $clog2(MEM_BYTES);
  localparam int SIDX_W  = IDX_W - SECTOR_SHIFT;

  // array storage and per sector erased markers
  logic [7:0]        mem      [MEM_BYTES];
  logic              erased_q [SECTORS];

  // register state
  logic [7:0]        ctrl_q;
  logic [7:0]        sech_q;
  logic [7:0]        secl_q;
  logic              err_q;

  // register write decode
  wire               wr_unlk;
  wire               wr_ctrl;
  wire               wr_sech;
  wire               wr_secl;
  wire               key_ok;
  assign wr_unlk = bus.reg_wr && (bus.reg_sel == SEL_UNLOCK);
  assign wr_ctrl = bus.reg_wr && (bus.reg_sel == SEL_CONTROL) && unlocked;
  assign wr_sech = bus.reg_wr && (bus.reg_sel == SEL_SECT_HIGH);
  assign wr_secl = bus.reg_wr && (bus.reg_sel == SEL_SECT_LOW);
  assign key_ok  = (bus.reg_wdata == UNLOCK_KEY);

  // sector and address decode
  wire [15:0]        sect_base;
  wire [15:0]        sect_addr;
  wire               in_mem;
  wire               base_ok;
  wire [IDX_W-1:0]   idx;
  wire [SIDX_W-1:0]  sidx;
  wire [SIDX_W-1:0]  bidx;
  wire               same_sect;
  assign sect_base = {sech_q, secl_q[7], 7'h00};
  assign sect_addr = {bus.tbl_addr[15:SECTOR_SHIFT], 7'h00};
  assign in_mem    = bus.tbl_addr < 16'(MEM_BYTES);
  assign base_ok   = sect_base < 16'(MEM_BYTES);
  assign idx       = bus.tbl_addr[IDX_W-1:0];
  assign sidx      = bus.tbl_addr[IDX_W-1:SECTOR_SHIFT];
  assign bidx      = sect_base[IDX_W-1:SECTOR_SHIFT];
  assign same_sect = (sect_addr == sect_base);

  // boot area protection
  wire               boot_hit_a;
  wire               boot_hit_s;
  assign boot_hit_a = boot_sector_en && (bus.tbl_addr >= BOOT_BASE) &&
                      (bus.tbl_addr <= boot_sector_top);
  assign boot_hit_s = boot_sector_en && (sect_base >= BOOT_BASE) &&
                      (sect_base <= boot_sector_top);

  // program, erase and lock qualification
  wire               prog_arm;
  wire               prog_ok;
  wire               erase_go;
  wire               erase_ok;
  wire               tool_erase;
  wire               tool_set;
  wire               lock_nib;
  wire               lock_set;
  assign prog_arm   = unlocked && (ctrl_q == CMD_PROGRAM);
  assign prog_ok    = bus.tbl_store && prog_arm && !hard_lock && in_mem &&
                      same_sect && erased_q[sidx] && !boot_hit_a;
  assign erase_go   = wr_ctrl && (bus.reg_wdata == CMD_ERASE);
  assign erase_ok   = erase_go && !hard_lock && base_ok && !boot_hit_s;
  assign tool_erase = tool_mode && tool_chip_erase;
  assign tool_set   = tool_mode && tool_lock;
  assign lock_nib   = (bus.reg_wdata[HARD_LOCK_MSB:HARD_LOCK_LSB] ==
                       HARD_LOCK_NIB);
  assign lock_set   = (wr_ctrl && lock_nib) || tool_set;

  // next register values
  wire               unlocked_d;
  wire               hard_lock_d;
  wire               err_d;
  wire [7:0]         status_d;
  assign unlocked_d  = wr_unlk ? key_ok : unlocked;
  assign hard_lock_d = tool_erase ? 1'b0 :
                       lock_set   ? 1'b1 : hard_lock;
  assign err_d       = erase_go      ? !erase_ok :
                       bus.tbl_store ? !prog_ok  : err_q;
  assign status_d    = {4'h0, err_d, 1'b0, hard_lock_d, unlocked_d};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked <= 1'b0;
    end else begin
      unlocked <= unlocked_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= bus.reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sech_q <= '0;
    end else if (wr_sech) begin
      sech_q <= bus.reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secl_q <= '0;
    end else if (wr_secl) begin
      secl_q <= bus.reg_wdata;
    end
  end

  // lock survives system reset, only a tool chip erase clears it
  always_ff @(posedge clk) begin
    hard_lock <= hard_lock_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error <= 1'b0;
    end else begin
      error <= err_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.tbl_rvalid <= 1'b0;
    end else begin
      bus.tbl_rvalid <= bus.tbl_load;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.tbl_rdata <= '0;
    end else if (bus.tbl_load) begin
      bus.tbl_rdata <= in_mem ? mem[idx] : 8'hff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.tbl_done <= 1'b0;
    end else begin
      bus.tbl_done <= bus.tbl_store | bus.tbl_load;
    end
  end

  // status mirrors unlocked, hard_lock and err_q in the same cycle as they change, but reset zeroes it; the error output lags a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.status <= '0;
    end else begin
      bus.status <= status_d;
    end
  end

  // array, no reset on storage
  always_ff @(posedge clk) begin
    if (prog_ok) begin
      mem[idx] <= bus.tbl_wdata;
    end
  end

  for (genvar s = 0; s < SECTORS; s++) begin : g_sect
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        erased_q[s] <= 1'b0;
      end else if (tool_erase) begin
        erased_q[s] <= 1'b1;
      end else if (erase_ok && (bidx == SIDX_W'(s))) begin
        erased_q[s] <= 1'b1;
      end else if (prog_ok && (sidx == SIDX_W'(s))) begin
        erased_q[s] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [fupl_if_asserts.sv]
// checker for the core end to flash controller interface
// assumes one clock; instantiated beside the interface in tb_top
`default_nettype none
module fupl_if_asserts
  import fupl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic [1:0]  reg_sel,
  input wire logic [7:0]  reg_wdata,
  input wire logic        tbl_load,
  input wire logic        tbl_store,
  input wire logic [15:0] tbl_addr,
  input wire logic        tbl_rvalid,
  input wire logic        tbl_done,
  input wire logic        chip_erase,
  input wire logic [7:0]  status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire key_wr = reg_wr && reg_sel == SEL_UNLOCK;
  wire ctl_wr = reg_wr && reg_sel == SEL_CONTROL;
  sequence s_arm; ctl_wr && reg_wdata == CMD_PROGRAM; endsequence
  sequence s_relock; !reg_wr ##1 key_wr && reg_wdata == UNLOCK_CLEAR;
  endsequence
  property p_read; tbl_load |=> tbl_rvalid ##1 !tbl_rvalid; endproperty
  property p_unlock; key_wr && reg_wdata == UNLOCK_KEY |=> status[0];
  endproperty
  property p_relock; key_wr && reg_wdata != UNLOCK_KEY |=> !status[0];
  endproperty
  property p_lock;
    ctl_wr && reg_wdata[7:4] == HARD_LOCK_NIB && status[0] |=> status[1];
  endproperty
  property p_sticky; status[1] && !chip_erase |=> status[1]; endproperty
  property p_clear; chip_erase |=> !status[1]; endproperty
  property p_done; tbl_load || tbl_store |=> tbl_done; endproperty
  property p_arm; s_arm |=> tbl_store; endproperty
  property p_tail; tbl_store |=> s_relock; endproperty
  property p_sect;
    tbl_store |-> $past(reg_wr, 2) && $past(reg_sel, 2) == SEL_SECT_LOW
      && $past(reg_wdata, 3) == tbl_addr[15:8];
  endproperty
  property p_refuse; tbl_store && status[1] |=> ##[0:1] status[3];
  endproperty
  a_read: assert property (p_read) else $error("no read answer");
  a_unlock: assert property (p_unlock) else $error("no unlock");
  a_relock: assert property (p_relock) else $error("no relock");
  a_lock: assert property (p_lock) else $error("lock not set");
  a_sticky: assert property (p_sticky) else $error("lock lost");
  a_arm: assert property (p_arm) else $error("no store");
  a_tail: assert property (p_tail) else $error("bad relock");
  a_sect: assert property (p_sect) else $error("bad sector");
  a_refuse: assert property (p_refuse) else $error("no refuse");
  a_clear: assert property (p_clear) else $error("lock kept");
  a_done: assert property (p_done) else $error("no table done");
endmodule
`default_nettype wire

// [tb_top.sv]
// testbench: core end and flash controller end joined by fupl_if
// assumes fupl_pkg, fupl_if and both design ends are compiled first
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: mismatch", $time); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0, rst_n = 1'h0, req = 1'h0, boot_en = 1'h0;
  logic        tool_mode = 1'h0, tool_lock = 1'h0, tool_erase = 1'h0;
  logic [1:0]  req_op = 2'h0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0]  req_data = 8'h00;
  wire logic   busy, done, hard_lock, unlocked, error;
  wire logic [7:0] rdata;
  int          err_count = 0, checked = 0, cyc = 0;
  always #20 clk = ~clk;
  fupl_if bus ();
  fupl_core_end i_fupl_core_end (.clk(clk), .rst_n(rst_n), .bus(bus),
    .req(req), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .busy(busy), .done(done), .rdata(rdata));
  fupl_flash_ctrl #(.MEM_BYTES(1024)) i_fupl_flash_ctrl (.clk(clk),
    .rst_n(rst_n), .bus(bus), .boot_sector_en(boot_en),
    .boot_sector_top(16'h01ff), .tool_mode(tool_mode),
    .tool_lock(tool_lock), .tool_chip_erase(tool_erase), .hard_lock(hard_lock),
    .unlocked(unlocked), .error(error));
  fupl_if_asserts i_fupl_if_asserts (.clk(clk), .rst_n(rst_n),
    .reg_wr(bus.reg_wr), .reg_sel(bus.reg_sel), .reg_wdata(bus.reg_wdata),
    .tbl_load(bus.tbl_load), .tbl_store(bus.tbl_store),
    .tbl_addr(bus.tbl_addr), .tbl_rvalid(bus.tbl_rvalid),
    .tbl_done(bus.tbl_done), .chip_erase(tool_mode && tool_erase),
    .status(bus.status));
  task automatic end_sim();
    $display("checked %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
  endtask
  // one request to the core end; returns one cycle after done
  task automatic run(input logic [1:0] op, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'h1; req_op <= op; req_addr <= a; req_data <= d;
    @(posedge clk);
    req <= 1'h0;
    do begin @(negedge clk); n++; end while (done !== 1'h1 && n < 60);
    `CHK(done, 1'h1)
    `CHK(busy, 1'h0)
    @(negedge clk);
  endtask
  task automatic t_tool();
    @(posedge clk);
    tool_mode <= 1'h1;
    tool_lock <= 1'h1;
    @(posedge clk);
    tool_mode <= 1'h0;
    tool_lock <= 1'h0;
    @(negedge clk);
    `CHK(hard_lock, 1'h1)
    do_reset();
    @(negedge clk);
    `CHK(hard_lock, 1'h1)
    @(posedge clk);
    tool_mode <= 1'h1;
    tool_erase <= 1'h1;
    @(posedge clk);
    tool_mode <= 1'h0;
    tool_erase <= 1'h0;
    @(negedge clk);
    `CHK(hard_lock, 1'h0)
    do_reset();
    $display("test tool lock done");
  endtask
  task automatic t_prog();
    run(2'h2, 16'h0280, 8'h00);
    `CHK(error, 1'h0)
    run(2'h0, 16'h0284, 8'h78);
    `CHK(error, 1'h0)
    `CHK(unlocked, 1'h0)
    run(2'h1, 16'h0284, 8'h00);
    `CHK(rdata, 8'h78)
    $display("test program done");
  endtask
  task automatic t_refuse();
    run(2'h0, 16'h0304, 8'h5a);
    `CHK(error, 1'h1)
    @(posedge clk);
    boot_en <= 1'h1;
    run(2'h2, 16'h0180, 8'h00);
    `CHK(error, 1'h1)
    @(posedge clk);
    boot_en <= 1'h0;
    $display("test refuse done");
  endtask
  task automatic t_lock();
    run(2'h2, 16'h0300, 8'h00);
    `CHK(error, 1'h0)
    run(2'h3, 16'h0000, 8'h00);
    `CHK(hard_lock, 1'h1)
    `CHK(unlocked, 1'h0)
    run(2'h2, 16'h0280, 8'h00);
    `CHK(error, 1'h1)
    run(2'h0, 16'h0304, 8'h11);
    `CHK(error, 1'h1)
    run(2'h1, 16'h0284, 8'h00);
    `CHK(rdata, 8'h78)
    `CHK(hard_lock, 1'h1)
    $display("test hard lock done");
  endtask
  initial begin
    do_reset();
    t_tool();
    t_prog();
    t_refuse();
    t_lock();
    end_sim();
  end
endmodule
`default_nettype wire
